// ===== rtl/ssf_defs.svh
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// register addresses on the serial read port
`define SSF_ADDR_ALIAS   8'h00
`define SSF_ADDR_P_MSB   8'h01
`define SSF_ADDR_P_CSB   8'h02
`define SSF_ADDR_P_LSB   8'h03
`define SSF_ADDR_T_MSB   8'h04
`define SSF_ADDR_T_LSB   8'h05
`define SSF_ADDR_STATUS  8'h06
`define SSF_ADDR_FDATA   8'h0e

// status bit positions
`define SSF_BIT_ANY_OW   7
`define SSF_BIT_PRESS_OW 6
`define SSF_BIT_TEMP_OW  5
`define SSF_BIT_RSVD_HI  4
`define SSF_BIT_ANY_RDY  3
`define SSF_BIT_PRESS_RDY 2
`define SSF_BIT_TEMP_RDY 1
`define SSF_BIT_RSVD_LO  0

// reset and fill values
`define SSF_STATUS_RST   8'h00
`define SSF_BYTE_ZERO    8'h00
`define SSF_NIBBLE_ZERO  4'h0

// fifo mode encodings
`define SSF_FMODE_OFF    2'h0
`define SSF_FMODE_CIRC   2'h1
`define SSF_FMODE_STOP   2'h2

`endif

// ===== rtl/ssf_pkg.sv
package ssf_pkg;
  `include "ssf_defs.svh"

  typedef enum logic [1:0] {
    fmode_off  = `SSF_FMODE_OFF,
    fmode_circ = `SSF_FMODE_CIRC,
    fmode_stop = `SSF_FMODE_STOP
  } ssf_fmode_t;

  typedef logic [7:0] ssf_byte_t;
endpackage

// ===== rtl/ssf_flag_pair.sv
`timescale 1ns/1ps
module ssf_flag_pair (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // acquisition events
  input  wire logic enable,
  input  wire logic sample_done,
  // retrieval by the host
  input  wire logic retrieve,
  // flags
  output logic      ready_flag,
  output logic      overwrite_flag
);
  logic event_hit;

  assign event_hit = enable && sample_done;

  // set wins over a retrieval in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_flag <= 1'b0;
    end else if (event_hit) begin
      ready_flag <= 1'b1;
    end else if (retrieve) begin
      ready_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overwrite_flag <= 1'b0;
    end else if (event_hit && ready_flag) begin
      overwrite_flag <= 1'b1;
    end else if (retrieve) begin
      overwrite_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_set_beats_clear;
    event_hit && retrieve |=> ready_flag;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("ready flag lost when set met clear");
endmodule

// ===== rtl/ssf_read_decode.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_read_decode (
  // register read request
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire ssf_pkg::ssf_fmode_t fifo_mode,
  // decoded results
  output logic                   fifo_on,
  output logic                   clr_press,
  output logic                   clr_temp,
  output logic                   addr_hit
);
  import ssf_pkg::*;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    addr_is = (a == b);
  endfunction

  always_comb begin
    fifo_on   = (fifo_mode != fmode_off);
    clr_press = 1'b0;
    clr_temp  = 1'b0;
    if (reg_rd) begin
      if (fifo_on) begin
        if (addr_is(reg_addr, `SSF_ADDR_P_MSB) || addr_is(reg_addr, `SSF_ADDR_FDATA)) begin
          clr_press = 1'b1;
          clr_temp  = 1'b1;
        end
      end else begin
        clr_press = addr_is(reg_addr, `SSF_ADDR_P_MSB);
        clr_temp  = addr_is(reg_addr, `SSF_ADDR_T_MSB);
      end
    end
    addr_hit = (reg_addr <= `SSF_ADDR_STATUS) || addr_is(reg_addr, `SSF_ADDR_FDATA);
  end
endmodule

// ===== rtl/ssf_sample_status.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_sample_status #(
  parameter int PRESS_W = 20,
  parameter int TEMP_W  = 12
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // acquisition engine
  input  wire logic                press_done,
  input  wire logic                temp_done,
  input  wire logic [PRESS_W-1:0]  press_result,
  input  wire logic [PRESS_W-1:0]  alt_result,
  input  wire logic [TEMP_W-1:0]   temp_result,
  // configuration bits
  input  wire logic                ready_event_enable,
  input  wire logic                press_event_enable,
  input  wire logic                temp_event_enable,
  input  wire logic                altimeter_select,
  input  wire ssf_pkg::ssf_fmode_t fifo_mode,
  // fifo side
  input  wire logic [7:0]          fifo_status,
  input  wire logic [7:0]          fifo_data,
  // register read port
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  output logic [7:0]               reg_rd_data,
  output logic                     reg_rd_valid,
  output logic                     reg_rd_hit,
  // status view
  output logic [7:0]               sample_status_reg
);
  import ssf_pkg::*;

  logic               press_ready_flag;
  logic               press_overwrite_flag;
  logic               temp_ready_flag;
  logic               temp_overwrite_flag;
  logic               any_ready_flag;
  logic               any_overwrite_flag;
  logic               fifo_on;
  logic               clr_press;
  logic               clr_temp;
  logic               addr_hit;
  logic               any_done;
  logic [PRESS_W-1:0] press_data;
  logic [TEMP_W-1:0]  temp_data;
  ssf_byte_t          p_msb_byte;
  ssf_byte_t          p_csb_byte;
  ssf_byte_t          p_lsb_byte;
  ssf_byte_t          t_msb_byte;
  ssf_byte_t          t_lsb_byte;
  ssf_byte_t          next_rd_data;

  assign any_done = press_done || temp_done;

  // read decode and retrieval strobes
  ssf_read_decode u_decode (
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .fifo_mode (fifo_mode),
    .fifo_on   (fifo_on),
    .clr_press (clr_press),
    .clr_temp  (clr_temp),
    .addr_hit  (addr_hit)
  );

  // per-type and combined flag cells
  ssf_flag_pair u_press (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .enable         (press_event_enable),
    .sample_done    (press_done),
    .retrieve       (clr_press),
    .ready_flag     (press_ready_flag),
    .overwrite_flag (press_overwrite_flag)
  );

  ssf_flag_pair u_temp (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .enable         (temp_event_enable),
    .sample_done    (temp_done),
    .retrieve       (clr_temp),
    .ready_flag     (temp_ready_flag),
    .overwrite_flag (temp_overwrite_flag)
  );

  ssf_flag_pair u_any (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .enable         (ready_event_enable),
    .sample_done    (any_done),
    .retrieve       (clr_press || clr_temp),
    .ready_flag     (any_ready_flag),
    .overwrite_flag (any_overwrite_flag)
  );

  // live sample registers, altitude or pressure by mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      press_data <= '0;
    end else if (press_done) begin
      press_data <= altimeter_select ? alt_result : press_result;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_data <= '0;
    end else if (temp_done) begin
      temp_data <= temp_result;
    end
  end

  // byte views of the samples, low nibble of lsb reads zero
  assign p_msb_byte = press_data[PRESS_W-1 -: 8];
  assign p_csb_byte = press_data[PRESS_W-9 -: 8];
  assign p_lsb_byte = {press_data[PRESS_W-17 -: 4], `SSF_NIBBLE_ZERO};
  assign t_msb_byte = temp_data[TEMP_W-1 -: 8];
  assign t_lsb_byte = {temp_data[TEMP_W-9 -: 4], `SSF_NIBBLE_ZERO};

  // status assembly, reserved bits tied low
  always_comb begin
    sample_status_reg                     = `SSF_STATUS_RST;
    sample_status_reg[`SSF_BIT_ANY_OW]    = any_overwrite_flag;
    sample_status_reg[`SSF_BIT_PRESS_OW]  = press_overwrite_flag;
    sample_status_reg[`SSF_BIT_TEMP_OW]   = temp_overwrite_flag;
    sample_status_reg[`SSF_BIT_ANY_RDY]   = any_ready_flag;
    sample_status_reg[`SSF_BIT_PRESS_RDY] = press_ready_flag;
    sample_status_reg[`SSF_BIT_TEMP_RDY]  = temp_ready_flag;
  end

  // read mux, area a depends on fifo mode
  always_comb begin
    next_rd_data = `SSF_BYTE_ZERO;
    case (reg_addr)
      `SSF_ADDR_ALIAS: begin
        next_rd_data = fifo_on ? fifo_status : sample_status_reg;
      end
      `SSF_ADDR_P_MSB: begin
        next_rd_data = fifo_on ? fifo_data : p_msb_byte;
      end
      `SSF_ADDR_P_CSB: begin
        next_rd_data = fifo_on ? `SSF_BYTE_ZERO : p_csb_byte;
      end
      `SSF_ADDR_P_LSB: begin
        next_rd_data = fifo_on ? `SSF_BYTE_ZERO : p_lsb_byte;
      end
      `SSF_ADDR_T_MSB: begin
        next_rd_data = fifo_on ? `SSF_BYTE_ZERO : t_msb_byte;
      end
      `SSF_ADDR_T_LSB: begin
        next_rd_data = fifo_on ? `SSF_BYTE_ZERO : t_lsb_byte;
      end
      `SSF_ADDR_STATUS: begin
        next_rd_data = sample_status_reg;
      end
      `SSF_ADDR_FDATA: begin
        next_rd_data = fifo_data;
      end
      default: begin
        next_rd_data = `SSF_BYTE_ZERO;
      end
    endcase
  end

  // read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_data <= `SSF_BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_valid <= 1'b0;
      reg_rd_hit   <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      reg_rd_hit   <= reg_rd && addr_hit;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_press_event;
    press_done && press_event_enable;
  endsequence

  sequence s_temp_event;
    temp_done && temp_event_enable;
  endsequence

  sequence s_any_event;
    any_done && ready_event_enable;
  endsequence

  sequence s_pmsb_read_off;
    reg_rd && !fifo_on && reg_addr == `SSF_ADDR_P_MSB;
  endsequence

  sequence s_tmsb_read_off;
    reg_rd && !fifo_on && reg_addr == `SSF_ADDR_T_MSB;
  endsequence

  sequence s_fdata_read;
    reg_rd && fifo_on && reg_addr == `SSF_ADDR_FDATA;
  endsequence

  sequence s_alias_read;
    reg_rd && reg_addr == `SSF_ADDR_ALIAS;
  endsequence

  property p_any_overwrite;
    s_any_event ##0 any_ready_flag |=> sample_status_reg[`SSF_BIT_ANY_OW];
  endproperty
  a_any_overwrite: assert property (p_any_overwrite)
    else $error("combined overwrite not set on unread result");

  property p_press_overwrite;
    s_press_event ##0 press_ready_flag |=> sample_status_reg[`SSF_BIT_PRESS_OW];
  endproperty
  a_press_overwrite: assert property (p_press_overwrite)
    else $error("pressure overwrite not set on unread result");

  property p_temp_overwrite;
    s_temp_event ##0 temp_ready_flag |=> sample_status_reg[`SSF_BIT_TEMP_OW];
  endproperty
  a_temp_overwrite: assert property (p_temp_overwrite)
    else $error("temperature overwrite not set on unread result");

  property p_any_ready;
    s_any_event |=> sample_status_reg[`SSF_BIT_ANY_RDY];
  endproperty
  a_any_ready: assert property (p_any_ready)
    else $error("combined ready not set on new result");

  property p_ready_pair;
    s_press_event ##0 s_temp_event |=> press_ready_flag && temp_ready_flag;
  endproperty
  a_ready_pair: assert property (p_ready_pair)
    else $error("per-type ready flags not set together");

  property p_press_clear;
    s_pmsb_read_off ##0 !press_done |=> !press_ready_flag && !press_overwrite_flag;
  endproperty
  a_press_clear: assert property (p_press_clear)
    else $error("pressure flags not cleared by high byte read");

  property p_temp_clear;
    s_tmsb_read_off ##0 !temp_done |=> !temp_ready_flag && !temp_overwrite_flag;
  endproperty
  a_temp_clear: assert property (p_temp_clear)
    else $error("temperature flags not cleared by high byte read");

  property p_any_clear;
    (s_pmsb_read_off or s_tmsb_read_off) ##0 !any_done
      |=> !any_ready_flag && !any_overwrite_flag;
  endproperty
  a_any_clear: assert property (p_any_clear)
    else $error("combined flags not cleared by high byte read");

  property p_fifo_clear;
    s_fdata_read ##0 !any_done |=> sample_status_reg == `SSF_STATUS_RST;
  endproperty
  a_fifo_clear: assert property (p_fifo_clear)
    else $error("fifo data read left a flag set");

  property p_fifo_no_msb_clear;
    reg_rd && fifo_on && reg_addr == `SSF_ADDR_T_MSB && temp_ready_flag
      |=> temp_ready_flag;
  endproperty
  a_fifo_no_msb_clear: assert property (p_fifo_no_msb_clear)
    else $error("high byte read cleared a flag with fifo on");

  property p_reserved_low;
    !sample_status_reg[`SSF_BIT_RSVD_HI] && !sample_status_reg[`SSF_BIT_RSVD_LO];
  endproperty
  a_reserved_low: assert property (p_reserved_low)
    else $error("reserved status bit seen high");

  property p_alias_status;
    s_alias_read ##0 !fifo_on
      |=> reg_rd_valid && reg_rd_data == $past(sample_status_reg);
  endproperty
  a_alias_status: assert property (p_alias_status)
    else $error("alias read did not return sample status");

  property p_alias_fifo;
    s_alias_read ##0 fifo_on |=> reg_rd_data == $past(fifo_status);
  endproperty
  a_alias_fifo: assert property (p_alias_fifo)
    else $error("alias read did not return fifo status");

  property p_any_gated;
    !ready_event_enable && !any_ready_flag |=> !any_ready_flag && !any_overwrite_flag;
  endproperty
  a_any_gated: assert property (p_any_gated)
    else $error("combined flag set with its event disabled");

  property p_press_gated;
    !press_event_enable && !press_ready_flag [*2] |=> !press_ready_flag;
  endproperty
  a_press_gated: assert property (p_press_gated)
    else $error("pressure flag set with its event disabled");

  property p_data_live;
    s_pmsb_read_off |=> reg_rd_data == $past(p_msb_byte);
  endproperty
  a_data_live: assert property (p_data_live)
    else $error("pressure high byte not the live sample");

  property p_status_read_keeps;
    reg_rd && reg_addr == `SSF_ADDR_STATUS ##0 sample_status_reg != `SSF_STATUS_RST
      |=> sample_status_reg != `SSF_STATUS_RST;
  endproperty
  a_status_read_keeps: assert property (p_status_read_keeps)
    else $error("status read cleared flags");
endmodule

// ===== verif/ssf_host_model.sv
`timescale 1ns/1ps
module ssf_host_model (
  // clock
  input  wire logic       clk,
  // read request
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  // read answer
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid,
  input  wire logic       reg_rd_hit
);
  initial begin
    reg_rd = 1'b0;
    reg_addr = 8'h00;
  end

  // one-cycle strobe, answer taken at the edge that samples valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    int n;
    d = 8'hxx;
    h = 1'bx;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      if (reg_rd_valid === 1'b1) begin
        d = reg_rd_data;
        h = reg_rd_hit;
        break;
      end
    end
  endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ssf_pkg::*;
  logic             clk;
  logic             sys_rst;
  logic             press_done;
  logic             temp_done;
  logic [19:0]      press_result;
  logic [19:0]      alt_result;
  logic [11:0]      temp_result;
  logic             ready_event_enable;
  logic             press_event_enable;
  logic             temp_event_enable;
  logic             altimeter_select;
  ssf_fmode_t       fifo_mode;
  logic [7:0]       fifo_status;
  logic [7:0]       fifo_data;
  logic             reg_rd;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_rd_data;
  logic             reg_rd_valid;
  logic             reg_rd_hit;
  logic [7:0]       sample_status_reg;
  int               n_mismatch;
  int               checked;

  ssf_sample_status dut (
    .clk(clk), .sys_rst(sys_rst), .press_done(press_done), .temp_done(temp_done),
    .press_result(press_result), .alt_result(alt_result), .temp_result(temp_result),
    .ready_event_enable(ready_event_enable), .press_event_enable(press_event_enable),
    .temp_event_enable(temp_event_enable), .altimeter_select(altimeter_select),
    .fifo_mode(fifo_mode), .fifo_status(fifo_status), .fifo_data(fifo_data),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .reg_rd_hit(reg_rd_hit),
    .sample_status_reg(sample_status_reg)
  );

  ssf_host_model host (
    .clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .reg_rd_hit(reg_rd_hit)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // read one byte and compare data and hit
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e,
                     input logic eh);
    logic [7:0] d;
    logic       h;
    host.rd(a, d, h);
    chk(nm, e, d);
    chk({nm, "_hit"}, {7'h00, eh}, {7'h00, h});
  endtask

  task automatic pulse(input logic p, input logic t);
    @(posedge clk);
    press_done <= p;
    temp_done <= t;
    @(posedge clk);
    press_done <= 1'b0;
    temp_done <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset();
    chk("status_rst", 8'h00, sample_status_reg);
    rdc("rd06_rst", 8'h06, 8'h00, 1'b1);
    rdc("rd07", 8'h07, 8'h00, 1'b0);
  endtask

  task automatic t_press();
    pulse(1'b1, 1'b0);
    chk("p_rdy", 8'h0c, sample_status_reg);
    rdc("rd06", 8'h06, 8'h0c, 1'b1);
    rdc("rd00", 8'h00, 8'h0c, 1'b1);
    pulse(1'b1, 1'b0);
    chk("p_ow", 8'hcc, sample_status_reg);
    rdc("rd01", 8'h01, 8'ha5, 1'b1);
    chk("p_clr", 8'h00, sample_status_reg);
    rdc("rd02", 8'h02, 8'hc3, 1'b1);
    rdc("rd03", 8'h03, 8'h70, 1'b1);
  endtask

  // done pulse meets a clearing read, then a reset in mid-run
  task automatic t_race();
    logic [7:0] d;
    logic       h;
    fork
      host.rd(8'h01, d, h);
      pulse(1'b1, 1'b0);
    join
    chk("race_rd", 8'ha5, d);
    chk("race_set", 8'h0c, sample_status_reg);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("rst_mid", 8'h00, sample_status_reg);
    rdc("rd01_rst", 8'h01, 8'h00, 1'b1);
  endtask

  task automatic t_temp();
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    chk("t_ow", 8'haa, sample_status_reg);
    rdc("rd04", 8'h04, 8'h9b, 1'b1);
    chk("t_clr", 8'h00, sample_status_reg);
    rdc("rd05", 8'h05, 8'h40, 1'b1);
  endtask

  task automatic t_alt();
    altimeter_select <= 1'b1;
    pulse(1'b1, 1'b0);
    rdc("rd01_alt", 8'h01, 8'h3c, 1'b1);
    altimeter_select <= 1'b0;
  endtask

  task automatic t_gate();
    ready_event_enable <= 1'b0;
    pulse(1'b1, 1'b0);
    pulse(1'b1, 1'b0);
    chk("no_any", 8'h44, sample_status_reg);
    ready_event_enable <= 1'b1;
    press_event_enable <= 1'b0;
    rdc("rd01_g", 8'h01, 8'ha5, 1'b1);
    pulse(1'b1, 1'b0);
    pulse(1'b1, 1'b0);
    chk("no_press", 8'h88, sample_status_reg);
    press_event_enable <= 1'b1;
    temp_event_enable <= 1'b0;
    pulse(1'b0, 1'b1);
    chk("no_temp", 8'h88, sample_status_reg);
    temp_event_enable <= 1'b1;
    rdc("rd01_g2", 8'h01, 8'ha5, 1'b1);
  endtask

  task automatic t_fifo(input ssf_fmode_t m);
    fifo_mode <= m;
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b1);
    chk("f_set", 8'hee, sample_status_reg);
    rdc("f_rd00", 8'h00, 8'h5a, 1'b1);
    rdc("f_rd04", 8'h04, 8'h00, 1'b1);
    chk("f_keep", 8'hee, sample_status_reg);
    rdc("f_rd0e", 8'h0e, 8'hd7, 1'b1);
    chk("f_clr", 8'h00, sample_status_reg);
    pulse(1'b0, 1'b1);
    rdc("f_rd01", 8'h01, 8'hd7, 1'b1);
    chk("f_clr1", 8'h00, sample_status_reg);
    fifo_mode <= fmode_off;
    @(posedge clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    sys_rst = 1'b1;
    press_done = 1'b0;
    temp_done = 1'b0;
    press_result = 20'ha_5c37;
    alt_result = 20'h3_c1e9;
    temp_result = 12'h9b4;
    ready_event_enable = 1'b1;
    press_event_enable = 1'b1;
    temp_event_enable = 1'b1;
    altimeter_select = 1'b0;
    fifo_mode = fmode_off;
    fifo_status = 8'h5a;
    fifo_data = 8'hd7;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_press();
    t_race();
    t_temp();
    t_alt();
    t_gate();
    t_fifo(fmode_circ);
    t_fifo(fmode_stop);
    results();
  end
endmodule
